//--- design/twtx_exec.sv
// Execution unit for table write, test-skip, xor and extended enable.
// Assumes one instruction word per cycle with prefetched next word.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "twtx_defines.svh"
module twtx_exec
    import twtx_pkg::*;
#(
    parameter int PTR_W = 21,
    parameter int HOLD_N = 8
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic next_two_word,
    // Operands from core
    input wire logic [7:0] w_in,
    input wire logic [7:0] file_in,
    input wire logic [7:0] table_latch,
    input wire logic [3:0] bank_select_reg,
    input wire logic extended_set_cfg_bit,
    input wire logic hold_consume,
    // Results
    output logic [7:0] w_out,
    output logic w_we,
    output logic [7:0] file_out,
    output logic file_we,
    output logic [11:0] file_addr,
    output logic indexed_mode,
    output logic flag_n,
    output logic flag_z,
    output logic flags_we,
    output logic flush,
    output logic busy,
    output logic [PTR_W-1:0] table_byte_pointer,
    output logic byte_high,
    output logic ext_op,
    output logic [1:0] ext_ptr_sel,
    output logic [5:0] ext_literal,
    output logic ext_sub,
    output logic ext_return,
    output logic ext_enabled,
    output logic [HOLD_N*8-1:0] hold_flat
);
    // Elaboration checks on the parameters
    if (PTR_W != 21)
    begin : g_bad_ptr_w
        $error("pointer width must be 21");
    end
    if (HOLD_N != 8)
    begin : g_bad_hold_n
        $error("eight holding registers expected");
    end
    ////////////////////////////////////////////////////////////////////////////
    // Decode
    localparam int HIDX_W = $clog2(HOLD_N);
    twtx_state_e state_reg, state_next;
    logic ext_cfg_reg; // Extension enable registered from the config bit every cycle
    logic [PTR_W-1:0] ptr_reg, ptr_next;
    // Active only while sequencer idle
    wire go = instr_valid && (state_reg == TWTX_IDLE);
    wire is_tbl_wr = go && instr[15:2] == `TWTX_OP_TBL_WR_HI;
    wire [1:0] pmode = instr[1:0];
    wire is_xor_lit = go && instr[15:8] == `TWTX_OP_XOR_LIT;
    wire is_xor_file = go && instr[15:10] == `TWTX_OP_XOR_FILE;
    wire is_tst = go && instr[15:9] == `TWTX_OP_TEST_SKIP;
    wire is_ext = go && ext_cfg_reg && instr[15:8] == `TWTX_OP_EXT_HI;
    wire is_extsub = go && ext_cfg_reg && instr[15:8] == (`TWTX_OP_EXT_HI | 8'h01);
    wire acc_bit = instr[8];
    wire dest_bit = instr[9];
    // Address formation, used for both file instructions
    function automatic logic [11:0] faddr(input logic a, input logic [7:0] f,
                                          input logic [3:0] bank);
        faddr = a ? {bank, f} : {4'h0, f};
    endfunction
    function automatic logic idx(input logic a, input logic [7:0] f, input logic e);
        idx = !a && e && (f <= `TWTX_IDX_LIMIT);
    endfunction
    wire [7:0] xres = w_in ^ (is_xor_lit ? instr[7:0] : file_in);
    wire file_op = is_xor_file || is_tst;
    wire tst_zero = is_tst && file_in == 8'h00;
    // Pointer stepping, wraps naturally at PTR_W bits
    wire [PTR_W-1:0] ptr_inc = ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    wire [PTR_W-1:0] ptr_dec = ptr_reg - {{(PTR_W-1){1'b0}}, 1'b1};
    wire [PTR_W-1:0] wr_ptr = (pmode == `TWTX_PM_PREINC) ? ptr_inc : ptr_reg;
    always_comb
    begin
        ptr_next = ptr_reg;
        if (is_tbl_wr)
        begin
            case (pmode)
                `TWTX_PM_POSTINC: ptr_next = ptr_inc;
                `TWTX_PM_POSTDEC: ptr_next = ptr_dec;
                `TWTX_PM_PREINC: ptr_next = ptr_inc;
                default: ptr_next = ptr_reg;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: multi-cycle occupancy
    always_comb
    begin
        state_next = TWTX_IDLE;
        case (state_reg)
            TWTX_IDLE:
            begin
                if (is_tbl_wr)
                    state_next = TWTX_TBL2;
                else if (tst_zero)
                    state_next = next_two_word ? TWTX_SKIP2 : TWTX_SKIP1;
                else if ((is_ext || is_extsub) && instr[7:6] == `TWTX_PTR2_SEL)
                    state_next = TWTX_SKIP1;
            end
            TWTX_SKIP2: state_next = TWTX_SKIP1;
            default: state_next = TWTX_IDLE;
        endcase
    end
    // State and pointer
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= TWTX_IDLE;
            ptr_reg <= `TWTX_PTR_RST;
        end
        else
        begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
        end
    end
    // Config bit sampled on every clock once out of reset
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            ext_cfg_reg <= 1'b0;
        else
            ext_cfg_reg <= extended_set_cfg_bit;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Holding registers stage flash data
    twtx_hold_regs #(.DEPTH(HOLD_N)) u_hold (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(is_tbl_wr),
        .wr_idx(wr_ptr[HIDX_W-1:0]),
        .wr_data(table_latch),
        .consume(hold_consume),
        .hold_flat(hold_flat)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            w_out <= 8'h00;
            w_we <= 1'b0;
            file_out <= 8'h00;
            file_we <= 1'b0;
            file_addr <= 12'h000;
            indexed_mode <= 1'b0;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            flags_we <= 1'b0;
            flush <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            w_out <= xres;
            w_we <= is_xor_lit || (is_xor_file && !dest_bit);
            file_out <= xres;
            file_we <= is_xor_file && dest_bit;
            file_addr <= faddr(acc_bit, instr[7:0], bank_select_reg);
            indexed_mode <= file_op && idx(acc_bit, instr[7:0], ext_cfg_reg);
            flag_n <= xres[7];
            flag_z <= xres == 8'h00;
            flags_we <= is_xor_lit || is_xor_file;
            flush <= tst_zero || state_next == TWTX_SKIP2 || state_reg == TWTX_SKIP2;
            busy <= state_next != TWTX_IDLE;
        end
    end
    // Pointer view and extended op outputs
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            table_byte_pointer <= `TWTX_PTR_RST;
            byte_high <= 1'b0;
            ext_op <= 1'b0;
            ext_ptr_sel <= 2'h0;
            ext_literal <= 6'h00;
            ext_sub <= 1'b0;
            ext_return <= 1'b0;
            ext_enabled <= 1'b0;
        end
        else
        begin
            table_byte_pointer <= ptr_next;
            byte_high <= ptr_next[0];
            ext_op <= is_ext || is_extsub;
            ext_ptr_sel <= instr[7:6];
            ext_literal <= instr[5:0];
            ext_sub <= is_extsub;
            ext_return <= (is_ext || is_extsub) && instr[7:6] == `TWTX_PTR2_SEL;
            ext_enabled <= ext_cfg_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    xor_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (is_xor_lit || is_xor_file) |=> flags_we && flag_z == (w_out == 8'h00))
        else $error("xor flags wrong");
    tst_noflag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (is_tst || is_tbl_wr) |=> !flags_we)
        else $error("flags touched");
    // Two-word skip: two refused cycles after the test, free on the third edge
    skip_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (tst_zero && next_two_word) |=> busy ##1 busy ##1 !busy)
        else $error("skip length wrong");
    skip_flush_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tst_zero |=> flush)
        else $error("no flush on zero");
    ptr_post_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (is_tbl_wr && pmode == `TWTX_PM_POSTDEC) |=> table_byte_pointer == $past(ptr_dec))
        else $error("pointer step wrong");
    ext_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !ext_cfg_reg |=> !ext_op)
        else $error("extension active");
    xor_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        is_xor_file |=> file_we != w_we)
        else $error("xor destination wrong");
    bank_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (file_op && acc_bit) |=> file_addr[11:8] == $past(bank_select_reg))
        else $error("bank address wrong");
endmodule
`default_nettype wire

//--- design/twtx_defines.svh
// Constants for the table-write / test-skip / xor execution block.
// Assumes inclusion by bare name from design files only.
`ifndef TWTX_DEFINES_SVH
`define TWTX_DEFINES_SVH
// Opcode patterns
`define TWTX_OP_TBL_WR_HI 14'h0003
`define TWTX_OP_XOR_LIT 8'h0A
`define TWTX_OP_XOR_FILE 6'h06
`define TWTX_OP_TEST_SKIP 7'h33
`define TWTX_OP_EXT_HI 8'hE8
// Pointer modes
`define TWTX_PM_NONE 2'h0
`define TWTX_PM_POSTINC 2'h1
`define TWTX_PM_POSTDEC 2'h2
`define TWTX_PM_PREINC 2'h3
// Indexed literal offset upper limit
`define TWTX_IDX_LIMIT 8'h5F
// Third pointer select value
`define TWTX_PTR2_SEL 2'h3
// Table pointer reset value
`define TWTX_PTR_RST 21'h000000
// Holding register value after reset or consumption (erased)
`define TWTX_HOLD_ERASED 8'hFF
`endif

//--- design/twtx_pkg.sv
// Types for the table-write / test-skip / xor execution block.
// Assumes nothing of its surroundings.
package twtx_pkg;
    // Execution sequencer states
    typedef enum logic [1:0] {TWTX_IDLE, TWTX_TBL2, TWTX_SKIP1, TWTX_SKIP2} twtx_state_e;
endpackage

//--- design/twtx_hold_regs.sv
// Eight-entry holding register bank for program memory staging.
// Assumes writes arrive on the core clock from the executor.
`timescale 1ns/1ps
`default_nettype none
`include "twtx_defines.svh"
module twtx_hold_regs
    import twtx_pkg::*;
#(
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Write side
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Consume side (program sequence clears after use)
    input wire logic consume,
    // Contents
    output logic [DEPTH*8-1:0] hold_flat
);
    localparam int IDX_W = $clog2(DEPTH);
    // Elaboration check: at least two entries so the index has a bit
    if (DEPTH < 2)
    begin : g_bad_depth
        $error("DEPTH too small");
    end
    // Storage array
    logic [7:0] mem_reg [DEPTH];
    genvar gi;
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_ent
        // Entry keeps value until written, consumed or reset
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
                mem_reg[gi] <= `TWTX_HOLD_ERASED;
            else if (wr_en && wr_idx == IDX_W'(gi))
                mem_reg[gi] <= wr_data;
            else if (consume)
                mem_reg[gi] <= `TWTX_HOLD_ERASED;
        end
        assign hold_flat[gi*8 +: 8] = mem_reg[gi];
    end
endmodule
`default_nettype wire

//--- verification/table_write_test_xor_exec_test.sv
// Self-checking bench for the table write, test-skip and xor execution block.
// Assumes the design package and the twtx_exec module are compiled first.
`timescale 1ns/1ps
`default_nettype none
module table_write_test_xor_exec_test;
    import twtx_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic ref_clk, rst_b, instr_valid, next_two_word, ext_cfg, hold_consume;
    logic [15:0] instr;
    logic [7:0] w_in, file_in, table_latch, w_out, file_out, res;
    logic [3:0] bank_select_reg;
    logic [11:0] file_addr;
    logic [20:0] table_byte_pointer, ptr_e;
    logic [1:0] ext_ptr_sel;
    logic [5:0] ext_literal;
    logic [63:0] hold_flat;
    logic w_we, file_we, indexed_mode, flag_n, flag_z, flags_we, flush, busy, byte_high;
    logic ext_op, ext_sub, ext_return, ext_enabled, tofile;
    int n_mismatch = 0;
    int check_count = 0;
    int k;
    // Expected holding bytes and pointer modes to walk through
    logic [7:0] hold_e [8];
    logic [1:0] tmode [7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3};
    // Xor cases: opcode, w, file, extension, expected address and indexing
    typedef struct packed {logic [15:0] op; logic [7:0] w; logic [7:0] f; logic ext;
        logic [11:0] addr; logic idx;} twtx_row_s;
    twtx_row_s rows [8] = '{
        '{16'h0AAF, 8'hB5, 8'h00, 1'b0, 12'h000, 1'b0},
        '{16'h0AFF, 8'hFF, 8'h00, 1'b0, 12'h000, 1'b0},
        '{16'h0A80, 8'h00, 8'h00, 1'b0, 12'h000, 1'b0},
        '{16'h1A20, 8'hB5, 8'hAF, 1'b0, 12'h020, 1'b0},
        '{16'h1934, 8'h0F, 8'h0F, 1'b0, 12'h534, 1'b0},
        '{16'h1A5F, 8'h01, 8'h80, 1'b1, 12'h05F, 1'b1},
        '{16'h1860, 8'h3C, 8'h0F, 1'b1, 12'h060, 1'b0},
        '{16'h1B10, 8'h00, 8'h00, 1'b1, 12'h510, 1'b0}};
    ////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Block under test
    twtx_exec dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr(instr), .next_two_word(next_two_word), .w_in(w_in), .file_in(file_in),
        .table_latch(table_latch), .bank_select_reg(bank_select_reg),
        .extended_set_cfg_bit(ext_cfg), .hold_consume(hold_consume), .w_out(w_out),
        .w_we(w_we), .file_out(file_out), .file_we(file_we), .file_addr(file_addr),
        .indexed_mode(indexed_mode), .flag_n(flag_n), .flag_z(flag_z),
        .flags_we(flags_we), .flush(flush), .busy(busy),
        .table_byte_pointer(table_byte_pointer), .byte_high(byte_high), .ext_op(ext_op),
        .ext_ptr_sel(ext_ptr_sel), .ext_literal(ext_literal), .ext_sub(ext_sub),
        .ext_return(ext_return), .ext_enabled(ext_enabled), .hold_flat(hold_flat));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Set extension a cycle ahead, issue one word, stop at the answer cycle
    task automatic exec(input logic [15:0] op, input logic [7:0] w, input logic [7:0] f,
        input logic e, input logic [7:0] tl);
        @(posedge ref_clk);
        ext_cfg <= e;
        @(posedge ref_clk);
        instr <= op;
        w_in <= w;
        file_in <= f;
        table_latch <= tl;
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
    endtask
    // Bounded wait until the block is free again
    task automatic settle();
        for (int m = 0; m < 4 && busy === 1'b1; m++)
            @(negedge ref_clk);
    endtask
    // Expected holding bank as one vector
    function automatic logic [63:0] hflat();
        logic [63:0] v;
        for (int i = 0; i < 8; i++)
            v[8*i+:8] = hold_e[i];
        return v;
    endfunction
    // Verdict and end of run
    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        #2000000;
        n_mismatch++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {instr_valid, next_two_word, ext_cfg, hold_consume, rst_b} = 5'h00;
        {instr, w_in, file_in, table_latch} = 40'h0;
        bank_select_reg = 4'h5;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        chk(table_byte_pointer, 21'h000000);
        chk(hold_flat, {8{8'hFF}});
        chk(ext_enabled, 1'b0);
        // Xor table
        foreach (rows[i])
        begin
            exec(rows[i].op, rows[i].w, rows[i].f, rows[i].ext, 8'h00);
            res = rows[i].w ^ (rows[i].op[12] ? rows[i].f : rows[i].op[7:0]);
            tofile = rows[i].op[12] & rows[i].op[9];
            chk(tofile ? file_out : w_out, res);
            chk({w_we, file_we}, {~tofile, tofile});
            chk({flags_we, flag_n, flag_z}, {1'b1, res[7], res == 8'h00});
            if (rows[i].op[12])
                chk({file_addr, indexed_mode}, {rows[i].addr, rows[i].idx});
            settle();
        end
        // Table writes in all pointer modes, wrapping both ways
        hold_e = '{default: 8'hFF};
        ptr_e = 21'h000000;
        for (int j = 0; j < 7; j++)
        begin
            if (tmode[j] == 2'h3)
                ptr_e++;
            hold_e[ptr_e[2:0]] = 8'(17 * (j + 1));
            exec({14'h0003, tmode[j]}, 8'h00, 8'h00, 1'b0, 8'(17 * (j + 1)));
            if (tmode[j] == 2'h1)
                ptr_e++;
            else if (tmode[j] == 2'h2)
                ptr_e--;
            chk(table_byte_pointer, ptr_e);
            chk(byte_high, ptr_e[0]);
            chk({flags_we, busy}, 2'h1);
            chk(hold_flat, hflat());
            settle();
        end
        // Programming sequence takes the staged bytes
        @(posedge ref_clk);
        hold_consume <= 1'b1;
        @(posedge ref_clk);
        hold_consume <= 1'b0;
        @(negedge ref_clk);
        chk(hold_flat, {8{8'hFF}});
        // Test-skip: no skip, skip, skip over a two-word instruction
        for (int j = 0; j < 3; j++)
        begin
            @(posedge ref_clk);
            next_two_word <= (j == 2);
            exec(j == 1 ? 16'h6720 : 16'h6620, 8'h00, j == 0 ? 8'h05 : 8'h00, 1'b0, 8'h00);
            chk(flags_we, 1'b0);
            for (k = 0; k < 4 && flush === 1'b1; k++)
                @(negedge ref_clk);
            chk(k, j);
            settle();
        end
        // Extended opcodes off, then on
        exec(16'hE8C5, 8'h00, 8'h00, 1'b0, 8'h00);
        chk({ext_op, ext_enabled}, 2'h0);
        settle();
        exec(16'hE845, 8'h00, 8'h00, 1'b1, 8'h00);
        chk({ext_op, ext_ptr_sel, ext_literal, ext_sub, ext_return, ext_enabled},
            {1'b1, 2'h1, 6'h05, 3'h1});
        settle();
        exec(16'hE9C7, 8'h00, 8'h00, 1'b1, 8'h00);
        chk({ext_op, ext_ptr_sel, ext_literal, ext_sub, ext_return, ext_enabled},
            {1'b1, 2'h3, 6'h07, 3'h7});
        settle();
        // Reset in mid-run drops pointer, staged bytes and extension
        exec({14'h0003, 2'h1}, 8'h00, 8'h00, 1'b1, 8'hA5);
        chk({table_byte_pointer, hold_flat[7:0]}, {21'h000001, 8'hA5});
        @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        chk({table_byte_pointer, ext_enabled}, 22'h000000);
        chk(hold_flat, {8{8'hFF}});
        close_out();
    end
endmodule
`default_nettype wire
